// *** verilog/pmi_device.sv ***
// slave port of the power-management device: register file on the bus
// assumes link_clk oversamples the bus at least ten times per bit;
// clk is the system side which receives committed writes
`timescale 1ns/1ps
`include "pmi_defines.svh"
module pmi_device
	import pmi_pkg::*;
#(
	parameter int NUM_REGS = `PMI_NUM_REGS,
	parameter pmi_pkg::pmi_byte_t REG_DEFAULT = `PMI_REG_DEFAULT
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic sleep_req,
	input wire logic uvlo_below,
	input wire logic hard_rst_n,
	pmi_bus_if.dev bus,
	output logic wr_pulse,
	output pmi_pkg::pmi_byte_t wr_addr,
	output pmi_pkg::pmi_byte_t wr_data
);
	import pmi_pkg::*;

	localparam int IW = $clog2(NUM_REGS);

	logic [3:0] ctl_s;
	logic [1:0] pin_s;
	logic lnk_rst;
	logic sleep_s;
	logic scl_s;
	logic sda_s;
	logic scl_p_q;
	logic sda_p_q;
	logic rise;
	logic fall;
	logic start;
	logic stop;
	pmi_dev_st_e st_q;
	logic [3:0] bit_q;
	pmi_byte_t sh_q;
	pmi_byte_t ptr_q;
	logic rd_dir_q;
	logic ack_q;
	logic ack_d;
	logic drive_q;
	logic commit;
	pmi_byte_t mem [NUM_REGS];
	logic wr_tgl_q;
	pmi_byte_t wa_q;
	pmi_byte_t wd_q;
	logic tgl_s;
	logic tgl_r_q;

	// pointer lands on an implemented register
	function automatic logic ptr_ok(input pmi_byte_t p);
		ptr_ok = (p >= `PMI_PTR_FIRST) && (p <= `PMI_PTR_LAST);
	endfunction : ptr_ok

	// status registers refuse host data
	function automatic logic ptr_ro(input pmi_byte_t p);
		ptr_ro = (p == `PMI_RO_PGOOD) || (p == `PMI_RO_CHG_STAT) ||
			(p == `PMI_RO_ADC_HI) || (p == `PMI_RO_ADC_LO);
	endfunction : ptr_ro

	// system reset, sleep and the two reset pins cross into the link domain
	pmi_sync #(
		.W(4)
	) u_ctl_sync (
		.clk(link_clk),
		.d({sys_rst, sleep_req, uvlo_below, hard_rst_n}),
		.q(ctl_s)
	);

	// bus lines are asynchronous pins
	pmi_sync #(
		.W(2)
	) u_pin_sync (
		.clk(link_clk),
		.d({bus.scl, bus.sda}),
		.q(pin_s)
	);

	assign lnk_rst = ctl_s[3] | ctl_s[1] | ~ctl_s[0]; // RULE_05
	assign sleep_s = ctl_s[2];
	assign scl_s = pin_s[1];
	assign sda_s = pin_s[0];

	// previous sampled levels for edge and condition detection
	always_ff @(posedge link_clk) begin
		scl_p_q <= scl_s;
		sda_p_q <= sda_s;
	end

	// data moving with clock high marks a condition, not a bit
	assign rise = scl_s & ~scl_p_q;
	assign fall = ~scl_s & scl_p_q;
	assign start = scl_s & scl_p_q & sda_p_q & ~sda_s; // RULE_09 RULE_17
	assign stop = scl_s & scl_p_q & ~sda_p_q & sda_s; // RULE_09

	// ack decision made as the eighth bit ends
	always_comb begin
		case (st_q)
			D_ADDR: ack_d = (sh_q == `PMI_WR_ADDR) ||
				(sh_q == `PMI_RD_ADDR); // RULE_01
			D_PTR: ack_d = ptr_ok(sh_q); // RULE_13 RULE_18
			D_WDATA: ack_d = ptr_ok(ptr_q) & ~ptr_ro(ptr_q); // RULE_19
			D_RDATA: ack_d = 1'b1;
			default: ack_d = 1'b0;
		endcase
	end

	// slave engine: start and stop win over any bit in flight
	always_ff @(posedge link_clk) begin
		if (lnk_rst | sleep_s | stop) begin
			st_q <= D_WAIT; // RULE_16
			bit_q <= 4'h0;
			drive_q <= 1'b0;
			ack_q <= 1'b0;
		end else if (start) begin
			st_q <= D_ADDR; // RULE_16 RULE_17
			// the clock fall closing the start is not a bit
			bit_q <= 4'hF;
			drive_q <= 1'b0;
		end else if (st_q != D_WAIT) begin
			// receive bits are taken on the rising clock
			if (rise && bit_q < 4'h8 && st_q != D_RDATA) begin
				sh_q <= {sh_q[6:0], sda_s};
			end
			if (fall) begin
				if (bit_q == 4'hF) begin
					bit_q <= 4'h0;
				end else if (bit_q < 4'h7) begin
					bit_q <= bit_q + 4'h1;
					if (st_q == D_RDATA) begin
						drive_q <= ~sh_q[7];
						sh_q <= {sh_q[6:0], 1'b1};
					end
				end else if (bit_q == 4'h7) begin
					bit_q <= 4'h8;
					ack_q <= ack_d;
					// read byte ends released for the host's answer
					drive_q <= ack_d & (st_q != D_RDATA); // RULE_10
					if (st_q == D_ADDR) begin
						rd_dir_q <= sh_q[0];
					end
				end else begin
					// ninth clock over: the line is let go, or takes the first data bit when a read follows the address
					bit_q <= 4'h0;
					drive_q <= 1'b0; // RULE_10
					if (!ack_q) begin
						st_q <= D_WAIT; // RULE_19
					end else begin
						case (st_q)
							D_ADDR: begin
								if (rd_dir_q) begin
									st_q <= D_RDATA; // RULE_15
									drive_q <= ~mem[ptr_q[IW-1:0]][7];
									sh_q <= {mem[ptr_q[IW-1:0]][6:0], 1'b1};
								end else begin
									st_q <= D_PTR; // RULE_03
								end
							end
							D_PTR: st_q <= D_WDATA;
							D_WDATA: st_q <= D_WAIT;
							D_RDATA: st_q <= D_WAIT; // RULE_06
							default: st_q <= D_WAIT;
						endcase
					end
				end
			end
		end
	end

	// pointer is stored only when the byte will be acked
	always_ff @(posedge link_clk) begin
		if (lnk_rst) begin
			ptr_q <= `PMI_PTR_RESET;
		end else if (!sleep_s && !stop && !start && fall &&
			st_q == D_PTR && bit_q == 4'h7 && ptr_ok(sh_q)) begin
			ptr_q <= sh_q; // RULE_13 RULE_18 RULE_19
		end
	end

	// a stop or start before the ack clock falls never reaches here
	assign commit = ~lnk_rst & ~sleep_s & ~stop & ~start & fall &
		(st_q == D_WDATA) & (bit_q == 4'h8) & ack_q; // RULE_14

	// register file; defaults stand in for the non-volatile bank
	always_ff @(posedge link_clk) begin
		if (lnk_rst) begin
			for (int i = 0; i < NUM_REGS; i++) begin
				mem[i] <= REG_DEFAULT; // RULE_04 RULE_05
			end
		end else if (commit) begin
			mem[ptr_q[IW-1:0]] <= sh_q; // RULE_14
		end
	end

	// write event leaves as a toggle; only the system reset clears it,
	// so a register restore is never seen as a write on the system side
	always_ff @(posedge link_clk) begin
		if (ctl_s[3]) begin
			wr_tgl_q <= 1'b0;
		end else if (commit) begin
			wr_tgl_q <= ~wr_tgl_q;
		end
	end

	// address and data held with the toggle
	always_ff @(posedge link_clk) begin
		if (lnk_rst) begin
			wa_q <= 8'h00;
			wd_q <= 8'h00;
		end else if (commit) begin
			wa_q <= ptr_q;
			wd_q <= sh_q;
		end
	end

	// slave only ever pulls low, so outside sleep it cannot form a condition
	assign bus.dev_sda_o = 1'b0; // RULE_07
	assign bus.dev_sda_oe_n = ~(drive_q | sleep_s); // RULE_08

	pmi_sync #(
		.W(1)
	) u_tgl_sync (
		.clk(clk),
		.d(wr_tgl_q),
		.q(tgl_s)
	);

	// system side: one pulse per committed write; words stable long since
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			tgl_r_q <= 1'b0;
			wr_pulse <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 8'h00;
		end else begin
			tgl_r_q <= tgl_s;
			wr_pulse <= tgl_s ^ tgl_r_q;
			if (tgl_s ^ tgl_r_q) begin
				wr_addr <= wa_q;
				wr_data <= wd_q;
			end
		end
	end
endmodule : pmi_device

// *** verilog/pmi_defines.svh ***
// constants of the power-management serial slave port and its host
// assumes inclusion by bare name from the package and the design files
// Operation
// RULE_01 - acknowledge only addresses 0x90 and 0x91
// RULE_02 - serial clock at most 400 kHz
// RULE_03 - first written byte is register pointer
// RULE_04 - registers load defaults at power-up
// RULE_05 - undervoltage or hard reset restores defaults
// RULE_06 - no pointer auto-increment; single-byte reads
// RULE_07 - slave never makes start or stop
// RULE_08 - sleep holds data low, released on wake
// RULE_09 - data changes only while clock low
// RULE_10 - slave acks each byte in ninth clock
// RULE_11 - read: write address, pointer, restart, read
// RULE_12 - stop or start ends any transfer
// RULE_13 - valid pointer stored and acked, else nack
// RULE_14 - data committed at ack, cancellable before
// RULE_15 - read returns register at stored pointer
// RULE_16 - start/stop preempt; stop returns to wait
// RULE_17 - repeated start treated as start
// RULE_18 - reserved pointer nacked and not loaded
// RULE_19 - read-only write: pointer kept, data nacked
// RULE_20 - host nacks read byte then ends
`ifndef PMI_DEFINES_SVH
`define PMI_DEFINES_SVH

`define PMI_WR_ADDR 8'h90
`define PMI_RD_ADDR 8'h91
`define PMI_PTR_FIRST 8'h02
`define PMI_PTR_LAST 8'h27
`define PMI_PTR_RESET 8'h00
`define PMI_RO_PGOOD 8'h02
`define PMI_RO_CHG_STAT 8'h0A
`define PMI_RO_ADC_HI 8'h1F
`define PMI_RO_ADC_LO 8'h20
`define PMI_NUM_REGS 64
`define PMI_REG_DEFAULT 8'h00
`define PMI_CLK_HZ 200000000
`define PMI_SCL_MAX_HZ 400000
// a least quarter period, rounded up so the clock never exceeds the limit
`define PMI_SCL_QTR_CYC \
	((`PMI_CLK_HZ + 4 * `PMI_SCL_MAX_HZ - 1) / (4 * `PMI_SCL_MAX_HZ))

`endif

// *** verilog/pmi_pkg.sv ***
// types shared by the serial slave port and its host
// assumes pmi_defines.svh holds all numeric constants
package pmi_pkg;
	`include "pmi_defines.svh"

	typedef logic [7:0] pmi_byte_t;

	// slave engine states
	typedef enum logic [2:0] {
		D_WAIT,
		D_ADDR,
		D_PTR,
		D_WDATA,
		D_RDATA
	} pmi_dev_st_e;

	// host sequencer states
	typedef enum logic [2:0] {
		H_IDLE,
		H_START,
		H_TX,
		H_RX,
		H_STOP
	} pmi_host_st_e;
endpackage : pmi_pkg

// *** verilog/pmi_bus_if.sv ***
// two-wire bus joining host and slave port
// assumes external pullups: a released line reads high
`timescale 1ns/1ps
interface pmi_bus_if;
	logic scl_o;
	logic scl_oe_n;
	logic host_sda_o;
	logic host_sda_oe_n;
	logic dev_sda_o;
	logic dev_sda_oe_n;
	wire scl;
	wire sda;

	// wired-and of the open-drain drivers over the pullup
	assign scl = scl_oe_n | scl_o;
	assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

	modport host (
		output scl_o,
		output scl_oe_n,
		output host_sda_o,
		output host_sda_oe_n,
		input sda
	);

	modport dev (
		output dev_sda_o,
		output dev_sda_oe_n,
		input scl,
		input sda
	);
endinterface : pmi_bus_if

// *** verilog/pmi_sync.sv ***
// two-flop synchroniser for levels entering a clock domain
// assumes each bit is an independent level, not a coded word
`timescale 1ns/1ps
module pmi_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk) begin
		meta_q <= d;
		q <= meta_q;
	end
endmodule : pmi_sync

// *** verilog/pmi_host.sv ***
// host end: one-byte register write or read over the two-wire bus
// assumes clk is the only clock; the serial clock is divided from it
`timescale 1ns/1ps
`include "pmi_defines.svh"
module pmi_host
	import pmi_pkg::*;
#(
	parameter int QTR = `PMI_SCL_QTR_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic req,
	input wire logic req_read,
	input wire pmi_pkg::pmi_byte_t req_ptr,
	input wire pmi_pkg::pmi_byte_t req_wdata,
	pmi_bus_if.host bus,
	output logic busy,
	output logic done,
	output logic nacked,
	output pmi_pkg::pmi_byte_t rdata
);
	import pmi_pkg::*;

	localparam int CW = $clog2(QTR + 1);
	localparam logic [CW-1:0] QLAST = CW'(QTR - 1);

	pmi_host_st_e st_q;
	logic [CW-1:0] qcnt_q;
	logic [1:0] ph_q;
	logic tick;
	logic [3:0] bit_q;
	logic [1:0] idx_q;
	logic rd_q;
	logic rest_q;
	logic ack_q;
	pmi_byte_t sh_q;
	pmi_byte_t rsh_q;
	pmi_byte_t wd_q;
	logic scl_d;
	logic sda_d;
	logic scl_q;
	logic sda_q;
	logic sda_s;

	pmi_sync #(
		.W(1)
	) u_sda_sync (
		.clk(clk),
		.d(bus.sda),
		.q(sda_s)
	);

	// quarter-period divider; four quarters make one serial clock
	always_ff @(posedge clk) begin
		if (sys_rst || st_q == H_IDLE) begin
			qcnt_q <= '0;
			ph_q <= 2'h0;
		end else if (tick) begin
			qcnt_q <= '0;
			ph_q <= ph_q + 2'h1;
		end else begin
			qcnt_q <= qcnt_q + CW'(1);
		end
	end
	assign tick = (qcnt_q == QLAST); // RULE_02

	// line levels per quarter; data bits move in quarter 0, clock low; start and stop move data in quarter 2, clock high
	always_comb begin
		scl_d = 1'b1;
		sda_d = 1'b1;
		case (st_q)
			H_START: begin
				scl_d = (ph_q == 2'h1) || (ph_q == 2'h2);
				sda_d = (ph_q < 2'h2);
			end
			H_TX: begin
				scl_d = (ph_q == 2'h1) || (ph_q == 2'h2); // RULE_09
				sda_d = (bit_q == 4'h8) ? 1'b1 : sh_q[7];
			end
			H_RX: begin
				scl_d = (ph_q == 2'h1) || (ph_q == 2'h2);
				sda_d = 1'b1; // RULE_20
			end
			H_STOP: begin
				scl_d = (ph_q != 2'h0);
				sda_d = (ph_q >= 2'h2);
			end
			default: begin
				scl_d = 1'b1;
				sda_d = 1'b1;
			end
		endcase
	end

	// line drivers from flops, open drain
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_d;
			sda_q <= sda_d;
		end
	end
	assign bus.scl_o = 1'b0;
	assign bus.scl_oe_n = scl_q;
	assign bus.host_sda_o = 1'b0;
	assign bus.host_sda_oe_n = sda_q;
	assign busy = (st_q != H_IDLE);

	// sampling in quarter 2, clock high
	always_ff @(posedge clk) begin
		if (tick && ph_q == 2'h2) begin
			if (st_q == H_TX && bit_q == 4'h8) begin
				ack_q <= ~sda_s;
			end
			if (st_q == H_RX && bit_q < 4'h8) begin
				rsh_q <= {rsh_q[6:0], sda_s};
			end
		end
	end

	// transfer sequencer; steps at the end of quarter 3
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			st_q <= H_IDLE;
			done <= 1'b0;
			nacked <= 1'b0;
			rdata <= 8'h00;
			bit_q <= 4'h0;
			idx_q <= 2'h0;
			rest_q <= 1'b0;
		end else begin
			done <= 1'b0;
			if (st_q == H_IDLE) begin
				if (req) begin
					st_q <= H_START;
					rd_q <= req_read;
					wd_q <= req_wdata;
					sh_q <= req_ptr;
					idx_q <= 2'h0;
					rest_q <= 1'b0;
					nacked <= 1'b0;
				end
			end else if (tick && ph_q == 2'h3) begin
				case (st_q)
					H_START: begin
						st_q <= H_TX;
						bit_q <= 4'h0;
						rdata <= sh_q;
						sh_q <= rest_q ? `PMI_RD_ADDR : `PMI_WR_ADDR;
						if (!rest_q) begin
							wd_q <= wd_q;
						end
					end
					H_TX: begin
						if (bit_q != 4'h8) begin
							bit_q <= bit_q + 4'h1;
							sh_q <= {sh_q[6:0], 1'b0};
						end else begin
							bit_q <= 4'h0;
							if (!ack_q) begin
								nacked <= 1'b1;
								st_q <= H_STOP; // RULE_12
							end else begin
								case (idx_q)
									2'h0: begin
										sh_q <= rdata; // RULE_03
										idx_q <= 2'h1;
									end
									2'h1: begin
										idx_q <= 2'h2;
										if (rd_q) begin
											st_q <= H_START; // RULE_11
											rest_q <= 1'b1;
										end else begin
											sh_q <= wd_q;
										end
									end
									2'h2: begin
										idx_q <= 2'h3;
										st_q <= rest_q ? H_RX : H_STOP;
									end
									default: st_q <= H_STOP;
								endcase
							end
						end
					end
					H_RX: begin
						if (bit_q != 4'h8) begin
							bit_q <= bit_q + 4'h1;
						end else begin
							st_q <= H_STOP; // RULE_06 RULE_20
						end
					end
					H_STOP: begin
						st_q <= H_IDLE;
						done <= 1'b1;
						if (rest_q) begin
							rdata <= rsh_q;
						end
					end
					default: st_q <= H_IDLE;
				endcase
			end
		end
	end
endmodule : pmi_host

// *** test/pmi_bus_asserts.sv ***
// assertions on the two-wire bus between the host and the slave port
// assumes plain bus signals; link helpers sample the wires directly
`timescale 1ns/1ps
`include "pmi_defines.svh"
module pmi_bus_asserts #(
	parameter int QTR = 125
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic sleep_req,
	input wire logic dev_sda_o,
	input wire logic dev_sda_oe_n,
	input wire logic scl,
	input wire logic sda
);
	logic scl_p, sda_p, scl_c, idle_q, rd_q;
	logic [3:0] bit_q;
	logic [1:0] byte_q;
	logic [7:0] sh_q, ptr_q;
	logic [5:0] slp_q;
	logic [15:0] per_q;
	wire logic dev_low = !dev_sda_oe_n && !dev_sda_o;
	// sleep pulls the line whatever the clock does, so bus checks pause
	wire logic quiet = sys_rst || sleep_req || (slp_q != 6'h00);
	wire logic start_ev = scl && scl_p && sda_p && !sda;
	wire logic stop_ev = scl && scl_p && !sda_p && sda;
	wire logic rise_ev = scl && !scl_p;
	wire logic ack_ev = rise_ev && bit_q == 4'h8;
	wire logic ro_ptr = ptr_q == `PMI_RO_PGOOD || ptr_q == `PMI_RO_CHG_STAT
		|| ptr_q == `PMI_RO_ADC_HI || ptr_q == `PMI_RO_ADC_LO;

	// wire history; only compared, so no reset
	always_ff @(posedge link_clk) begin
		scl_p <= scl;
		sda_p <= sda;
		slp_q <= {slp_q[4:0], sleep_req};
	end

	// bit and byte position inside the frame
	always_ff @(posedge link_clk) begin
		if (sys_rst || start_ev) begin
			bit_q <= 4'h0;
			byte_q <= 2'h0;
		end else if (ack_ev) begin
			bit_q <= 4'h0;
			byte_q <= byte_q + {1'b0, byte_q != 2'h3};
		end else if (rise_ev) begin
			bit_q <= bit_q + 4'h1;
		end
	end

	// received bits, direction bit and pointer byte
	always_ff @(posedge link_clk) begin
		if (rise_ev && !ack_ev)
			sh_q <= {sh_q[6:0], sda};
		if (ack_ev && byte_q == 2'h0)
			rd_q <= sh_q[0];
		if (ack_ev && byte_q == 2'h1)
			ptr_q <= sh_q;
	end

	// bus idle from stop until the next start
	always_ff @(posedge link_clk) begin
		if (sys_rst || stop_ev)
			idle_q <= 1'b1;
		else if (start_ev)
			idle_q <= 1'b0;
	end

	// cycles between serial clock rises, saturating
	always_ff @(posedge clk) begin
		scl_c <= scl;
		if (sys_rst)
			per_q <= 16'hFFFF;
		else if (scl && !scl_c)
			per_q <= 16'h0000;
		else if (per_q != 16'hFFFF)
			per_q <= per_q + 16'h0001;
	end

	chk_dev_sda_edge: assert property (@(posedge link_clk)
		disable iff (quiet) $changed(dev_low) |-> !scl)
		else $error("slave moved data while clock high");
	chk_scl_period_min: assert property (@(posedge clk)
		disable iff (sys_rst) (scl && !scl_c) |-> per_q >= 4 * QTR - 1)
		else $error("serial clock period too short");
	chk_addr_ack: assert property (@(posedge link_clk)
		disable iff (quiet) (ack_ev && byte_q == 2'h0)
		|-> sda == ((sh_q | 8'h01) != `PMI_RD_ADDR))
		else $error("address acknowledge wrong");
	chk_ptr_ack: assert property (@(posedge link_clk)
		disable iff (quiet) (ack_ev && byte_q == 2'h1 && !rd_q)
		|-> sda == (sh_q < `PMI_PTR_FIRST || sh_q > `PMI_PTR_LAST))
		else $error("pointer acknowledge wrong");
	chk_data_ack: assert property (@(posedge link_clk)
		disable iff (quiet) (ack_ev && byte_q == 2'h2 && !rd_q) |-> sda == ro_ptr)
		else $error("data acknowledge wrong");
	chk_read_nack: assert property (@(posedge link_clk)
		disable iff (quiet) (ack_ev && byte_q == 2'h1 && rd_q) |-> sda)
		else $error("read byte not closed by not-acknowledge");
	chk_sleep_hold: assert property (@(posedge link_clk)
		disable iff (sys_rst) sleep_req [*6] |-> dev_low)
		else $error("data line not held in sleep");
	chk_sleep_release: assert property (@(posedge link_clk)
		disable iff (sys_rst) $fell(sleep_req) |-> ##[1:6] !dev_low)
		else $error("data line not released after sleep");
	chk_wait_quiet: assert property (@(posedge link_clk)
		disable iff (quiet) idle_q |-> !dev_low)
		else $error("slave drove the line after stop");
endmodule : pmi_bus_asserts

// *** test/tb_pmic_i2c_slave_port.sv ***
// self-checking bench: host and slave port joined over the two-wire bus
// assumes clk 200 MHz, link clock 160 ns, serial clock shortened by QTR
`timescale 1ns/1ps
`include "pmi_defines.svh"
module tb_pmic_i2c_slave_port;
	import pmi_pkg::*;
	localparam int QTR = 100;
	localparam int LIMIT = 100000;
	logic clk, link_clk, sys_rst, req, req_read, sleep_req;
	logic uvlo_below, hard_rst_n, busy, done, nacked, wr_pulse;
	pmi_byte_t req_ptr, req_wdata, rdata, wr_addr, wr_data, last_a, last_d;
	int fail_count = 0;
	int checks = 0;
	int cyc = 0;
	int wr_cnt = 0;

	pmi_bus_if i_pmi_bus_if();
	pmi_host #(.QTR(QTR)) i_pmi_host(.clk, .sys_rst, .req, .req_read,
		.req_ptr, .req_wdata, .bus(i_pmi_bus_if), .busy, .done, .nacked,
		.rdata);
	pmi_device i_pmi_device(.clk, .sys_rst, .link_clk, .sleep_req,
		.uvlo_below, .hard_rst_n, .bus(i_pmi_bus_if), .wr_pulse, .wr_addr,
		.wr_data);
	pmi_bus_asserts #(.QTR(QTR)) i_pmi_bus_asserts(.clk, .sys_rst,
		.link_clk, .sleep_req, .dev_sda_o(i_pmi_bus_if.dev_sda_o),
		.dev_sda_oe_n(i_pmi_bus_if.dev_sda_oe_n), .scl(i_pmi_bus_if.scl),
		.sda(i_pmi_bus_if.sda));

	// system clock
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// link clock, offset so its edges never meet the system clock's
	initial begin
		link_clk = 1'b0;
		#37;
		forever #80 link_clk = ~link_clk;
	end

	// committed writes on the system side, and the hang limit
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (wr_pulse === 1'b1) begin
			wr_cnt <= wr_cnt + 1;
			last_a <= wr_addr;
			last_d <= wr_data;
		end
		if (cyc == LIMIT) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check

	// link edges let the synchronisers settle; ends on a system edge
	task automatic link_wait(input int n);
		repeat (n) @(posedge link_clk);
		@(posedge clk);
	endtask : link_wait

	// one host command; done is looked at mid-cycle, away from the edge
	task automatic xfer(input logic rd, input pmi_byte_t ptr,
		input pmi_byte_t wd, input logic nk, input pmi_byte_t rexp);
		int n;
		n = 0;
		@(posedge clk);
		req <= 1'b1;
		req_read <= rd;
		req_ptr <= ptr;
		req_wdata <= wd;
		@(posedge clk);
		req <= 1'b0;
		@(negedge clk);
		check({7'h00, busy}, 8'h01);
		while (done !== 1'b1 && n < 30000) begin
			@(negedge clk);
			n++;
		end
		check({7'h00, done}, 8'h01);
		check({7'h00, busy}, 8'h00);
		check({7'h00, nacked}, {7'h00, nk});
		if (rd)
			check(rdata, rexp);
	endtask : xfer

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// main sequence
	initial begin
		sys_rst = 1'b1;
		req = 1'b0;
		req_read = 1'b0;
		req_ptr = 8'h00;
		req_wdata = 8'h00;
		sleep_req = 1'b0;
		uvlo_below = 1'b0;
		hard_rst_n = 1'b1;
		link_wait(6);
		sys_rst <= 1'b0;
		link_wait(4);
		xfer(1'b0, 8'h05, 8'hA5, 1'b0, 8'h00);
		check(last_a, 8'h05);
		check(last_d, 8'hA5);
		xfer(1'b1, 8'h05, 8'h00, 1'b0, 8'hA5);
		hard_rst_n <= 1'b0;
		link_wait(5);
		hard_rst_n <= 1'b1;
		link_wait(5);
		xfer(1'b1, 8'h05, 8'h00, 1'b0, `PMI_REG_DEFAULT);
		xfer(1'b0, `PMI_PTR_LAST, 8'h5A, 1'b0, 8'h00);
		check(last_a, `PMI_PTR_LAST);
		check(last_d, 8'h5A);
		uvlo_below <= 1'b1;
		link_wait(5);
		uvlo_below <= 1'b0;
		link_wait(5);
		xfer(1'b1, `PMI_PTR_LAST, 8'h00, 1'b0, `PMI_REG_DEFAULT);
		xfer(1'b0, `PMI_RO_CHG_STAT, 8'h3C, 1'b1, 8'h00);
		xfer(1'b0, 8'h28, 8'h3C, 1'b1, 8'h00);
		check(8'(wr_cnt), 8'h02);
		sleep_req <= 1'b1;
		link_wait(8);
		check({7'h00, i_pmi_bus_if.sda}, 8'h00);
		sleep_req <= 1'b0;
		link_wait(8);
		check({7'h00, i_pmi_bus_if.sda}, 8'h01);
		end_of_test();
	end
endmodule : tb_pmic_i2c_slave_port
